/* File: rtl/fxp_pkg.sv */
package fxp_pkg;
  // addressing modes
  typedef enum logic [1:0] {MODE_S, MODE_R, MODE_V, MODE_I} mode_t;

  // operations supplied by the decoder
  typedef enum logic [5:0] {
    OP_NOP,
    OP_MULTIPLY_LONG,
    OP_MULTIPLY_SINGLE,
    OP_PREP_DIVIDE_WIDEN,
    OP_PREP_DIVIDE_ACC_TO_LONG,
    OP_PREP_DIVIDE_HALF,
    OP_PREP_DIVIDE_LONG,
    OP_POST_MULTIPLY_NARROW,
    OP_POST_MULTIPLY_TO_ACC,
    OP_POST_MULTIPLY_HALF,
    OP_POST_MULTIPLY_LONG,
    OP_DECREMENT_ACC_ONE,
    OP_DECREMENT_ACC_TWO,
    OP_MINUS_MEMORY_ACC,
    OP_MINUS_MEMORY_LONG,
    OP_MINUS_MEMORY_FULL,
    OP_MINUS_MEMORY_HALF,
    OP_FORCE_SIGN_NEGATIVE,
    OP_FORCE_SIGN_POSITIVE,
    OP_NEGATE_ACCUMULATOR,
    OP_NEGATE_LONG,
    OP_INDIRECT_EFFADDR_TO_ACC,
    OP_EFFADDR_TO_ACCUMULATOR,
    OP_EFFADDR_TO_LONG,
    OP_EFFADDR_TO_LINK_BASE,
    OP_EFFADDR_TO_REGISTER,
    OP_EFFADDR_TO_AUX_BASE,
    OP_EFFADDR_TO_FIELD_ADDR,
    OP_DOUBLE_WORD_LOAD,
    OP_DOUBLE_WORD_STORE,
    OP_SWAP_ACC_PAIR,
    OP_SWAP_ACC_BYTES,
    OP_SWAP_BYTES_CLEAR_LEFT,
    OP_SWAP_BYTES_CLEAR_RIGHT,
    OP_HALF_SWAP_BYTES_CLEAR_LEFT,
    OP_HALF_SWAP_BYTES_CLEAR_RIGHT,
    OP_SWAP_HALVES_CLEAR_LEFT,
    OP_SWAP_HALVES_CLEAR_RIGHT,
    OP_SWAP_REGISTER_BYTES,
    OP_SWAP_REGISTER_HALVES,
    OP_SWAP_ACC_WITH_MEMORY,
    OP_SWAP_REG_WITH_MEMORY,
    OP_SWAP_HALF_WITH_MEMORY,
    OP_SWAP_EXTENSION_LONG,
    OP_LOAD_HALF_SHIFT_ONE,
    OP_LOAD_HALF_SHIFT_TWO,
    OP_LOAD_HALF_SHIFT_THREE
  } op_t;

  localparam int REG_COUNT = 8;
  localparam int FAR_COUNT = 2;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [15:0] HALF_RESET = 16'h0000;
  // sign position (documented bit 1) of each width
  localparam int SIGN16_POS = 15;
  localparam int SIGN32_POS = 31;
  localparam logic [15:0] DEC_ONE = 16'h0001;
  localparam logic [15:0] DEC_TWO = 16'h0002;
endpackage : fxp_pkg

/* File: rtl/byte_half_swap.sv */
`timescale 1ns/100ps
// swaps the two halves of a word, then optionally clears one half
module byte_half_swap #(
  parameter int HALF_W = 8
) (
  input wire logic [2*HALF_W-1:0] din,
  input wire logic clear_left,
  input wire logic clear_right,
  output logic [2*HALF_W-1:0] dout
);
  logic [HALF_W-1:0] new_left;
  logic [HALF_W-1:0] new_right;

  always_comb begin
    new_left = clear_left ? '0 : din[HALF_W-1:0];
    new_right = clear_right ? '0 : din[2*HALF_W-1:HALF_W];
    dout = {new_left, new_right};
  end
endmodule : byte_half_swap

/* File: rtl/fxp_datapath.sv */
`timescale 1ns/100ps
module fxp_datapath
  import fxp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // decoder request
  input wire logic op_valid,
  input wire op_t op_code,
  input wire mode_t op_mode,
  input wire logic [2:0] op_reg,
  input wire logic op_far_sel,
  input wire logic [31:0] eff_addr,
  // memory operand
  input wire logic [31:0] mem_rdata,
  input wire logic [15:0] mem_rdata2,
  // results
  output logic done_ff,
  output logic mem_we_ff,
  output logic mem_we2_ff,
  output logic [31:0] mem_wdata_ff,
  output logic [15:0] mem_wdata2_ff,
  output logic [15:0] acc_ff,
  output logic [15:0] accb_ff,
  output logic [31:0] ext_ff,
  output logic [31:0] link_base_ff,
  output logic [31:0] aux_base_ff
);
  // ==========================================================
  // reset release
  logic rst_s1_ff;
  logic rst_s2_ff;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end

  // ==========================================================
  // architectural state
  logic [31:0] gr_ff [REG_COUNT];
  logic [31:0] far_ff [FAR_COUNT];
  logic [31:0] nxt_gr [REG_COUNT];
  logic [31:0] nxt_far [FAR_COUNT];
  logic [15:0] nxt_acc;
  logic [15:0] nxt_accb;
  logic [31:0] nxt_ext;
  logic [31:0] nxt_link_base;
  logic [31:0] nxt_aux_base;
  logic nxt_done;
  logic nxt_mem_we;
  logic nxt_mem_we2;
  logic [31:0] nxt_mem_wdata;
  logic [15:0] nxt_mem_wdata2;

  // ==========================================================
  // shared operands
  logic [2:0] reg_next;
  logic [31:0] r_cur;
  logic [31:0] r_pair;
  logic [15:0] r_half;
  logic [31:0] long_val;
  logic [15:0] mem_h;
  logic [15:0] acc_swapped;
  logic [15:0] half_swapped;
  logic [31:0] full_swapped;
  logic sw_cl;
  logic sw_cr;
  logic hb_cl;
  logic hb_cr;
  logic hw_cl;
  logic hw_cr;
  logic signed [63:0] prod_long;
  logic signed [31:0] prod_short;
  logic signed [31:0] prod_half;

  assign reg_next = op_reg + 3'h1;
  assign r_cur = gr_ff[op_reg];
  assign r_pair = gr_ff[reg_next];
  // half register is the upper half of the register
  assign r_half = r_cur[31:16];
  // in V mode the long register is the accumulator pair
  assign long_val = {acc_ff, accb_ff};
  assign mem_h = mem_rdata[15:0];

  // two's complement products
  assign prod_long = $signed(long_val) * $signed(mem_rdata);
  assign prod_short = $signed(acc_ff) * $signed(mem_h);
  assign prod_half = $signed(r_half) * $signed(mem_h);

  // accumulator byte, register byte and register half swaps share one unit each
  always_comb begin
    sw_cl = (op_code == OP_SWAP_BYTES_CLEAR_LEFT);
    sw_cr = (op_code == OP_SWAP_BYTES_CLEAR_RIGHT);
    hb_cl = (op_code == OP_HALF_SWAP_BYTES_CLEAR_LEFT);
    hb_cr = (op_code == OP_HALF_SWAP_BYTES_CLEAR_RIGHT);
    hw_cl = (op_code == OP_SWAP_HALVES_CLEAR_LEFT);
    hw_cr = (op_code == OP_SWAP_HALVES_CLEAR_RIGHT);
  end

  byte_half_swap #(.HALF_W(8)) u_acc_swap (
    .din(acc_ff),
    .clear_left(sw_cl),
    .clear_right(sw_cr),
    .dout(acc_swapped)
  );
  byte_half_swap #(.HALF_W(8)) u_half_swap (
    .din(r_half),
    .clear_left(hb_cl),
    .clear_right(hb_cr),
    .dout(half_swapped)
  );
  byte_half_swap #(.HALF_W(16)) u_full_swap (
    .din(r_cur),
    .clear_left(hw_cl),
    .clear_right(hw_cr),
    .dout(full_swapped)
  );

  // ==========================================================
  // next-state: every update of one instruction lands on one edge
  always_comb begin
    for (int i = 0; i < REG_COUNT; i++) begin
      nxt_gr[i] = gr_ff[i];
    end
    for (int i = 0; i < FAR_COUNT; i++) begin
      nxt_far[i] = far_ff[i];
    end
    nxt_acc = acc_ff;
    nxt_accb = accb_ff;
    nxt_ext = ext_ff;
    nxt_link_base = link_base_ff;
    nxt_aux_base = aux_base_ff;
    nxt_done = op_valid;
    nxt_mem_we = 1'b0;
    nxt_mem_we2 = 1'b0;
    nxt_mem_wdata = mem_wdata_ff;
    nxt_mem_wdata2 = mem_wdata2_ff;
    if (op_valid) begin
      case (op_code)
        OP_MULTIPLY_LONG: begin
          {nxt_ext, nxt_acc, nxt_accb} = prod_long;
        end
        OP_MULTIPLY_SINGLE: begin
          if (op_mode == MODE_I) begin
            nxt_gr[op_reg] = prod_half[31:0];
          end else if (op_mode == MODE_V) begin
            {nxt_acc, nxt_accb} = prod_short;
          end else begin
            // pair keeps one sign; bit 1 of the second word is skipped
            nxt_acc = prod_short[31:16] << 1 | 16'(prod_short[15]);
            nxt_acc[SIGN16_POS] = prod_short[31];
            nxt_accb = {1'b0, prod_short[14:0]};
          end
        end
        OP_PREP_DIVIDE_WIDEN: begin
          if (op_mode == MODE_I) begin
            nxt_gr[reg_next] = r_cur;
            nxt_gr[op_reg] = {32{r_cur[SIGN32_POS]}};
          end else begin
            nxt_accb = {1'b0, acc_ff[14:0]};
            nxt_acc = {16{acc_ff[SIGN16_POS]}};
          end
        end
        OP_PREP_DIVIDE_ACC_TO_LONG: begin
          nxt_accb = {1'b0, acc_ff[14:0]};
          nxt_acc = {16{acc_ff[SIGN16_POS]}};
        end
        OP_PREP_DIVIDE_LONG: begin
          nxt_ext = {32{acc_ff[SIGN16_POS]}};
        end
        OP_PREP_DIVIDE_HALF: begin
          nxt_gr[op_reg] = 32'($signed(r_half));
        end
        OP_POST_MULTIPLY_NARROW: begin
          if (op_mode == MODE_I) begin
            nxt_gr[op_reg] = r_pair;
          end else begin
            nxt_acc = {acc_ff[SIGN16_POS], accb_ff[14:0]};
          end
        end
        OP_POST_MULTIPLY_TO_ACC: begin
          nxt_acc = accb_ff;
        end
        OP_POST_MULTIPLY_HALF: begin
          nxt_gr[op_reg] = {r_cur[15:0], r_cur[15:0]};
        end
        OP_POST_MULTIPLY_LONG: begin
          // low word already sits in the long register; extension left alone
          {nxt_acc, nxt_accb} = long_val;
        end
        OP_DECREMENT_ACC_ONE: nxt_acc = acc_ff - DEC_ONE;
        OP_DECREMENT_ACC_TWO: nxt_acc = acc_ff - DEC_TWO;
        OP_MINUS_MEMORY_ACC: nxt_acc = acc_ff - mem_h;
        OP_MINUS_MEMORY_LONG: {nxt_acc, nxt_accb} = long_val - mem_rdata;
        OP_MINUS_MEMORY_FULL: nxt_gr[op_reg] = r_cur - mem_rdata;
        OP_MINUS_MEMORY_HALF: begin
          nxt_gr[op_reg] = {r_half - mem_h, r_cur[15:0]};
        end
        OP_FORCE_SIGN_NEGATIVE: begin
          if (op_mode == MODE_I) nxt_gr[op_reg][SIGN32_POS] = 1'b1;
          else nxt_acc[SIGN16_POS] = 1'b1;
        end
        OP_FORCE_SIGN_POSITIVE: begin
          if (op_mode == MODE_I) nxt_gr[op_reg][SIGN32_POS] = 1'b0;
          else nxt_acc[SIGN16_POS] = 1'b0;
        end
        OP_NEGATE_ACCUMULATOR: nxt_acc = 16'(~acc_ff + DEC_ONE);
        OP_NEGATE_LONG: {nxt_acc, nxt_accb} = 32'(-long_val);
        // effective addresses are plain unsigned words
        OP_INDIRECT_EFFADDR_TO_ACC: nxt_acc = mem_h;
        OP_EFFADDR_TO_ACCUMULATOR: nxt_acc = eff_addr[15:0];
        OP_EFFADDR_TO_LONG: {nxt_acc, nxt_accb} = eff_addr;
        OP_EFFADDR_TO_LINK_BASE: nxt_link_base = eff_addr;
        OP_EFFADDR_TO_REGISTER: nxt_gr[op_reg] = eff_addr;
        OP_EFFADDR_TO_AUX_BASE: nxt_aux_base = eff_addr;
        OP_EFFADDR_TO_FIELD_ADDR: nxt_far[op_far_sel] = eff_addr;
        OP_DOUBLE_WORD_LOAD: begin
          nxt_acc = mem_h;
          nxt_accb = mem_rdata2;
        end
        OP_DOUBLE_WORD_STORE: begin
          nxt_mem_we = 1'b1;
          nxt_mem_we2 = 1'b1;
          nxt_mem_wdata = {HALF_RESET, acc_ff};
          nxt_mem_wdata2 = accb_ff;
        end
        OP_SWAP_ACC_PAIR: begin
          nxt_acc = accb_ff;
          nxt_accb = acc_ff;
        end
        OP_SWAP_ACC_BYTES, OP_SWAP_BYTES_CLEAR_LEFT, OP_SWAP_BYTES_CLEAR_RIGHT: begin
          nxt_acc = acc_swapped;
        end
        OP_HALF_SWAP_BYTES_CLEAR_LEFT, OP_HALF_SWAP_BYTES_CLEAR_RIGHT,
        OP_SWAP_REGISTER_BYTES: begin
          nxt_gr[op_reg] = {half_swapped, r_cur[15:0]};
        end
        OP_SWAP_HALVES_CLEAR_LEFT, OP_SWAP_HALVES_CLEAR_RIGHT,
        OP_SWAP_REGISTER_HALVES: begin
          nxt_gr[op_reg] = full_swapped;
        end
        OP_SWAP_ACC_WITH_MEMORY: begin
          nxt_acc = mem_h;
          nxt_mem_we = 1'b1;
          nxt_mem_wdata = {HALF_RESET, acc_ff};
        end
        OP_SWAP_REG_WITH_MEMORY: begin
          nxt_gr[op_reg] = mem_rdata;
          nxt_mem_we = 1'b1;
          nxt_mem_wdata = r_cur;
        end
        OP_SWAP_HALF_WITH_MEMORY: begin
          nxt_gr[op_reg] = {mem_h, r_cur[15:0]};
          nxt_mem_we = 1'b1;
          nxt_mem_wdata = {HALF_RESET, r_half};
        end
        OP_SWAP_EXTENSION_LONG: begin
          nxt_ext = long_val;
          {nxt_acc, nxt_accb} = ext_ff;
        end
        OP_LOAD_HALF_SHIFT_ONE: nxt_gr[op_reg] = {mem_h << 1, r_cur[15:0]};
        OP_LOAD_HALF_SHIFT_TWO: nxt_gr[op_reg] = {mem_h << 2, r_cur[15:0]};
        OP_LOAD_HALF_SHIFT_THREE: nxt_gr[op_reg] = {mem_h << 3, r_cur[15:0]};
        default: nxt_done = op_valid;
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk or negedge rst_s2_ff) begin
    if (!rst_s2_ff) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        gr_ff[i] <= REG_RESET;
      end
      for (int i = 0; i < FAR_COUNT; i++) begin
        far_ff[i] <= REG_RESET;
      end
      acc_ff <= HALF_RESET;
      accb_ff <= HALF_RESET;
      ext_ff <= REG_RESET;
      link_base_ff <= REG_RESET;
      aux_base_ff <= REG_RESET;
      done_ff <= 1'b0;
      mem_we_ff <= 1'b0;
      mem_we2_ff <= 1'b0;
      mem_wdata_ff <= REG_RESET;
      mem_wdata2_ff <= HALF_RESET;
    end else begin
      gr_ff <= nxt_gr;
      far_ff <= nxt_far;
      acc_ff <= nxt_acc;
      accb_ff <= nxt_accb;
      ext_ff <= nxt_ext;
      link_base_ff <= nxt_link_base;
      aux_base_ff <= nxt_aux_base;
      done_ff <= nxt_done;
      mem_we_ff <= nxt_mem_we;
      mem_we2_ff <= nxt_mem_we2;
      mem_wdata_ff <= nxt_mem_wdata;
      mem_wdata2_ff <= nxt_mem_wdata2;
    end
  end
endmodule : fxp_datapath

/* File: tb/fxp_mem_model.sv */
`timescale 1ns/100ps
module fxp_mem_model (
  // request side
  input wire logic clk,
  input wire logic [31:0] eff_addr,
  input wire logic mem_we_ff,
  input wire logic mem_we2_ff,
  input wire logic [31:0] mem_wdata_ff,
  input wire logic [15:0] mem_wdata2_ff,
  // operand words
  output logic [31:0] mem_rdata,
  output logic [15:0] mem_rdata2
);
  // ==========
  // word store
  logic [31:0] word_mem [8];
  logic [15:0] word2_mem [8];
  logic [2:0] addr_ff;
  initial begin
    for (int i = 0; i < 8; i++) begin
      word_mem[i] = 32'h9E37_79B9 * (i + 1);
      word2_mem[i] = 16'h3C5A ^ 16'(i * 16'h1111);
    end
  end
  // writes land one cycle after the request, so the address is kept
  always @(posedge clk) begin
    addr_ff <= eff_addr[2:0];
    if (mem_we_ff) word_mem[addr_ff] <= mem_wdata_ff;
    if (mem_we2_ff) word2_mem[addr_ff] <= mem_wdata2_ff;
  end
  assign mem_rdata = word_mem[eff_addr[2:0]];
  assign mem_rdata2 = word2_mem[eff_addr[2:0]];
endmodule : fxp_mem_model

/* File: tb/fxp_monitor.sv */
`timescale 1ns/100ps
module fxp_monitor
  import fxp_pkg::*;
(
  // clock, reset and request
  input wire logic clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire op_t op_code,
  input wire mode_t op_mode,
  input wire logic [31:0] eff_addr,
  // results
  input wire logic done_ff,
  input wire logic mem_we_ff,
  input wire logic [31:0] mem_wdata_ff,
  input wire logic [15:0] mem_wdata2_ff,
  input wire logic [15:0] acc_ff,
  input wire logic [15:0] accb_ff,
  input wire logic [31:0] ext_ff,
  input wire logic [31:0] link_base_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic a_op;
  assign a_op = op_valid && op_mode != MODE_I;
  // ==========
  // checks
  done_follows_a: assert property (op_valid |=> done_ff)
    else $error("done missing");
  no_extra_done_a: assert property (!op_valid |=> !done_ff)
    else $error("done without op");
  state_held_a: assert property (!op_valid |=> $stable({acc_ff, accb_ff, ext_ff}))
    else $error("state moved while idle");
  store_pair_a: assert property (a_op && op_code == OP_DOUBLE_WORD_STORE |=> mem_we_ff
    && mem_wdata_ff[15:0] == $past(acc_ff) && mem_wdata2_ff == $past(accb_ff))
    else $error("double store data wrong");
  dec_one_a: assert property (a_op && op_code == OP_DECREMENT_ACC_ONE
    |=> acc_ff == 16'($past(acc_ff) - DEC_ONE)) else $error("decrement wrong");
  negate_acc_a: assert property (a_op && op_code == OP_NEGATE_ACCUMULATOR
    |=> acc_ff == 16'(~$past(acc_ff) + 16'h0001)) else $error("negate wrong");
  sign_set_a: assert property (a_op && op_code == OP_FORCE_SIGN_NEGATIVE |=>
    acc_ff[SIGN16_POS] && acc_ff[14:0] == $past(acc_ff[14:0])) else $error("sign set wrong");
  pair_swap_a: assert property (a_op && op_code == OP_SWAP_ACC_PAIR |=>
    acc_ff == $past(accb_ff) && accb_ff == $past(acc_ff)) else $error("pair swap wrong");
  ext_swap_a: assert property (a_op && op_code == OP_SWAP_EXTENSION_LONG |=>
    ext_ff == $past({acc_ff, accb_ff}) && {acc_ff, accb_ff} == $past(ext_ff))
    else $error("extension swap wrong");
  link_base_a: assert property (op_valid && op_code == OP_EFFADDR_TO_LINK_BASE
    |=> link_base_ff == $past(eff_addr)) else $error("link base wrong");
  cover property (op_valid && op_code == OP_DOUBLE_WORD_STORE);
  cover property (op_valid && op_code == OP_MULTIPLY_LONG);
  cover property (op_valid && op_code == OP_SWAP_ACC_WITH_MEMORY ##1 op_valid);
endmodule : fxp_monitor
bind fxp_datapath fxp_monitor mon_u (.clk, .rst_b, .op_valid, .op_code, .op_mode, .eff_addr,
  .done_ff, .mem_we_ff, .mem_wdata_ff, .mem_wdata2_ff, .acc_ff, .accb_ff, .ext_ff,
  .link_base_ff);

/* File: tb/fxp_datapath_tb.sv */
`timescale 1ns/100ps
module fxp_datapath_tb
  import fxp_pkg::*;
;
  logic clk, rst_b, op_valid, op_far_sel, done_ff, mem_we_ff, mem_we2_ff;
  op_t op_code;
  mode_t op_mode;
  logic [2:0] op_reg;
  logic [31:0] eff_addr, mem_rdata, mem_wdata_ff, ext_ff, link_base_ff, aux_base_ff;
  logic [15:0] mem_rdata2, mem_wdata2_ff, acc_ff, accb_ff;
  logic [15:0] ma, mb, ewd2;
  logic [31:0] me, mlb, mxb, ewd;
  logic [31:0] mg [8];
  logic [31:0] mf [2];
  logic ewe, ew2;
  integer seed = 94622;
  int n_errors = 0;
  int cmp_count = 0;
  initial clk = 1'b0;
  always #2 clk = ~clk;
  fxp_datapath dut_u (.clk(clk), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .op_mode(op_mode), .op_reg(op_reg), .op_far_sel(op_far_sel), .eff_addr(eff_addr),
    .mem_rdata(mem_rdata), .mem_rdata2(mem_rdata2), .done_ff(done_ff),
    .mem_we_ff(mem_we_ff), .mem_we2_ff(mem_we2_ff), .mem_wdata_ff(mem_wdata_ff),
    .mem_wdata2_ff(mem_wdata2_ff), .acc_ff(acc_ff), .accb_ff(accb_ff), .ext_ff(ext_ff),
    .link_base_ff(link_base_ff), .aux_base_ff(aux_base_ff));
  fxp_mem_model pm_u (.clk(clk), .eff_addr(eff_addr), .mem_we_ff(mem_we_ff),
    .mem_we2_ff(mem_we2_ff), .mem_wdata_ff(mem_wdata_ff), .mem_wdata2_ff(mem_wdata2_ff),
    .mem_rdata(mem_rdata), .mem_rdata2(mem_rdata2));
  // ==========
  // compares
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic conclude();
    if (n_errors == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // ==========
  // reset, model cleared with it
  task automatic do_reset();
    rst_b = 1'b0;
    op_valid = 1'b0;
    {ma, mb, me, mlb, mxb} = '0;
    mg = '{default: 32'h0000_0000};
    mf = '{default: 32'h0000_0000};
    repeat (10) @(posedge clk);
    #1;
    chk({acc_ff, accb_ff}, {ma, mb});
    chk(ext_ff ^ link_base_ff ^ aux_base_ff, 32'h0000_0000);
    chk_bit(done_ff | mem_we_ff, 1'b0);
    rst_b = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask : do_reset
  // ==========
  // one cycle: model the chosen op, send it, compare one cycle later
  task automatic step(input logic go);
    logic ok;
    logic [31:0] rd, ea;
    logic [15:0] rd2;
    logic [2:0] r, rn;
    logic [63:0] p;
    op_t c;
    mode_t m;
    ok = 1'b0;
    {ewe, ew2} = 2'b00;
    c = OP_NOP;
    m = MODE_V;
    ea = '0;
    while (go && !ok) begin
      c = op_t'($unsigned($random(seed)) % 47);
      ea = $random(seed);
      r = ea[5:3];
      rn = r + 3'h1;
      rd = pm_u.word_mem[ea[2:0]];
      rd2 = pm_u.word2_mem[ea[2:0]];
      ok = 1'b1;
      m = MODE_V;
      case (c)
        OP_MULTIPLY_LONG: {me, ma, mb} = $signed({ma, mb}) * $signed(rd);
        OP_MULTIPLY_SINGLE: begin
          m = mode_t'($unsigned($random(seed)) % 4);
          if (m == MODE_I) begin
            p = $signed(mg[r][31:16]) * $signed(rd[15:0]);
            mg[r] = p[31:0];
          end else begin
            p = $signed(ma) * $signed(rd[15:0]);
            if (m == MODE_V) {ma, mb} = p[31:0];
            else {ma, mb} = {p[31], p[29:15], 1'b0, p[14:0]};
          end
        end
        OP_PREP_DIVIDE_WIDEN: begin
          m = $random(seed) & 1 ? MODE_I : MODE_R;
          if (m == MODE_I) begin
            mg[rn] = mg[r];
            mg[r] = {32{mg[r][31]}};
          end else begin
            p = $signed(ma);
            {ma, mb} = {p[30:15], 1'b0, p[14:0]};
          end
        end
        OP_PREP_DIVIDE_ACC_TO_LONG: {ma, mb} = {{16{ma[15]}}, 1'b0, ma[14:0]};
        OP_PREP_DIVIDE_HALF: begin
          m = MODE_I;
          mg[r] = {{16{mg[r][31]}}, mg[r][31:16]};
        end
        OP_POST_MULTIPLY_HALF: begin
          m = MODE_I;
          mg[r] = {mg[r][15:0], mg[r][15:0]};
        end
        OP_MINUS_MEMORY_FULL: begin
          m = MODE_I;
          mg[r] = mg[r] - rd;
        end
        OP_MINUS_MEMORY_HALF: begin
          m = MODE_I;
          mg[r][31:16] = mg[r][31:16] - rd[15:0];
        end
        OP_EFFADDR_TO_REGISTER: begin
          m = MODE_I;
          mg[r] = ea;
        end
        OP_EFFADDR_TO_FIELD_ADDR: mf[ea[6]] = ea;
        OP_HALF_SWAP_BYTES_CLEAR_LEFT: begin
          m = MODE_I;
          mg[r][31:16] = {8'h00, mg[r][31:24]};
        end
        OP_HALF_SWAP_BYTES_CLEAR_RIGHT: begin
          m = MODE_I;
          mg[r][31:16] = {mg[r][23:16], 8'h00};
        end
        OP_SWAP_REGISTER_BYTES: begin
          m = MODE_I;
          mg[r][31:16] = {mg[r][23:16], mg[r][31:24]};
        end
        OP_SWAP_HALVES_CLEAR_LEFT: begin
          m = MODE_I;
          mg[r] = {16'h0000, mg[r][31:16]};
        end
        OP_SWAP_HALVES_CLEAR_RIGHT: begin
          m = MODE_I;
          mg[r] = {mg[r][15:0], 16'h0000};
        end
        OP_SWAP_REGISTER_HALVES: begin
          m = MODE_I;
          mg[r] = {mg[r][15:0], mg[r][31:16]};
        end
        OP_SWAP_REG_WITH_MEMORY: begin
          m = MODE_I;
          ewe = 1'b1;
          ewd = mg[r];
          mg[r] = rd;
        end
        OP_SWAP_HALF_WITH_MEMORY: begin
          m = MODE_I;
          ewe = 1'b1;
          ewd = {16'h0000, mg[r][31:16]};
          mg[r][31:16] = rd[15:0];
        end
        OP_LOAD_HALF_SHIFT_ONE: begin
          m = MODE_I;
          mg[r][31:16] = rd[15:0] << 1;
        end
        OP_LOAD_HALF_SHIFT_TWO: begin
          m = MODE_I;
          mg[r][31:16] = rd[15:0] << 2;
        end
        OP_LOAD_HALF_SHIFT_THREE: begin
          m = MODE_I;
          mg[r][31:16] = rd[15:0] << 3;
        end
        OP_PREP_DIVIDE_LONG: me = {32{ma[SIGN16_POS]}};
        OP_POST_MULTIPLY_NARROW: begin
          m = $random(seed) & 1 ? MODE_I : MODE_S;
          if (m == MODE_I) mg[r] = mg[rn];
          else ma = {ma[SIGN16_POS], mb[14:0]};
        end
        OP_POST_MULTIPLY_TO_ACC: ma = mb;
        OP_POST_MULTIPLY_LONG: ok = 1'b1;
        OP_DECREMENT_ACC_ONE: ma -= DEC_ONE;
        OP_DECREMENT_ACC_TWO: ma -= DEC_TWO;
        OP_MINUS_MEMORY_ACC: ma -= rd[15:0];
        OP_MINUS_MEMORY_LONG: {ma, mb} -= rd;
        OP_FORCE_SIGN_NEGATIVE: ma[SIGN16_POS] = 1'b1;
        OP_FORCE_SIGN_POSITIVE: ma[SIGN16_POS] = 1'b0;
        OP_NEGATE_ACCUMULATOR: ma = -ma;
        OP_NEGATE_LONG: {ma, mb} = -{ma, mb};
        OP_INDIRECT_EFFADDR_TO_ACC: begin
          m = MODE_S;
          ma = rd[15:0];
        end
        OP_EFFADDR_TO_ACCUMULATOR: ma = ea[15:0];
        OP_EFFADDR_TO_LONG: {ma, mb} = ea;
        OP_EFFADDR_TO_LINK_BASE: mlb = ea;
        OP_EFFADDR_TO_AUX_BASE: mxb = ea;
        OP_DOUBLE_WORD_LOAD: begin
          m = MODE_S;
          {ma, mb} = {rd[15:0], rd2};
        end
        OP_DOUBLE_WORD_STORE: begin
          m = MODE_S;
          {ewe, ew2} = 2'b11;
          ewd = {16'h0000, ma};
          ewd2 = mb;
        end
        OP_SWAP_ACC_PAIR: {ma, mb} = {mb, ma};
        OP_SWAP_ACC_BYTES: ma = {ma[7:0], ma[15:8]};
        OP_SWAP_BYTES_CLEAR_LEFT: ma = {8'h00, ma[15:8]};
        OP_SWAP_BYTES_CLEAR_RIGHT: ma = {ma[7:0], 8'h00};
        OP_SWAP_EXTENSION_LONG: {me, ma, mb} = {ma, mb, me};
        OP_SWAP_ACC_WITH_MEMORY: begin
          ewe = 1'b1;
          ewd = {16'h0000, ma};
          ma = rd[15:0];
        end
        default: ok = 1'b0;
      endcase
    end
    op_valid = go;
    op_code = c;
    op_mode = m;
    eff_addr = ea;
    op_reg = ea[5:3];
    op_far_sel = ea[6];
    @(posedge clk);
    #1;
    chk_bit(done_ff, go);
    chk({acc_ff, accb_ff}, {ma, mb});
    chk(ext_ff, me);
    chk(link_base_ff, mlb);
    chk(aux_base_ff, mxb);
    chk_bit(mem_we_ff, ewe);
    chk_bit(mem_we2_ff, ew2);
    if (ewe) chk(mem_wdata_ff, ewd);
    for (int i = 0; i < 8; i++) chk(dut_u.gr_ff[i], mg[i]);
    chk(dut_u.far_ff[op_far_sel], mf[op_far_sel]);
    if (ew2) chk({16'h0000, mem_wdata2_ff}, {16'h0000, ewd2});
  endtask : step
  // ==========
  // main sequence, with a second reset in mid-run
  initial begin
    {op_valid, op_far_sel, op_reg, eff_addr} = '0;
    op_code = OP_NOP;
    op_mode = MODE_V;
    do_reset();
    repeat (1500) step(($random(seed) & 7) != 0);
    do_reset();
    repeat (500) step(($random(seed) & 7) != 0);
    conclude();
  end
  initial begin
    #40000;
    n_errors++;
    conclude();
  end
endmodule : fxp_datapath_tb
